// *** verilog/gpdpc_top.sv ***
`timescale 1ns/100ps
// pin port: direction, level, pull enable and polarity per two-way pin
module gpdpc_top (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [31:0] i_periph_own,
   input wire logic [31:0] i_xtal_pin,
   input wire logic [31:0] i_pin_in,
   output logic [31:0] o_pin_out,
   output logic [31:0] o_pin_oe,
   output logic [31:0] o_pull_en,
   output logic [31:0] o_pull_up
);
   gpdpc_pkg::gpdpc_pair_t pair;
   gpdpc_pkg::gpdpc_state_t st;
   gpdpc_pkg::gpdpc_state_t next_st;
   logic [31:0] pin_meta;
   logic [31:0] pin_sync;
   logic [31:0] own_meta;
   logic [31:0] own_sync;
   logic [31:0] next_pen_raw;
   logic [1:0] sel;
   logic do_apply;
   logic [31:0] mu_cur;
   logic [31:0] mu_next;
   logic mu_clr_wins;

   // staging of the two masks of the next update
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pair <= '0;
      end else if (i_wr) begin
         if (i_addr == gpdpc_pkg::ADDR_DIR_IN || i_addr == gpdpc_pkg::ADDR_LVL_ON ||
             i_addr == gpdpc_pkg::ADDR_PEN_ON || i_addr == gpdpc_pkg::ADDR_POL_UP) begin
            pair.set_mask <= i_wdata;
         end else if (i_addr == gpdpc_pkg::ADDR_DIR_OUT || i_addr == gpdpc_pkg::ADDR_LVL_OFF ||
                      i_addr == gpdpc_pkg::ADDR_PEN_OFF || i_addr == gpdpc_pkg::ADDR_POL_DOWN) begin
            pair.clr_mask <= i_wdata;
         end
      end
   end

   // apply write selects the state word; wdata[1:0] names it
   always_comb begin
      do_apply = i_wr && (i_addr == gpdpc_pkg::ADDR_APPLY);
      sel = i_wdata[1:0];
      case (sel)
         gpdpc_pkg::UPD_DIR: begin
            mu_cur = st.dir_out;
            mu_clr_wins = 1'b1; // clear = input mask
         end
         gpdpc_pkg::UPD_LVL: begin
            mu_cur = st.level;
            mu_clr_wins = 1'b1;
         end
         gpdpc_pkg::UPD_PEN: begin
            mu_cur = st.pull_en;
            mu_clr_wins = 1'b1;
         end
         default: begin
            mu_cur = st.pull_up;
            mu_clr_wins = 1'b0;
         end
      endcase
   end

   // direction uses input mask as clear, output mask as set
   gpdpc_mask_update #(
      .WIDTH(32)
   ) u_upd (
      .i_cur(mu_cur),
      .i_set((sel == gpdpc_pkg::UPD_DIR) ? pair.clr_mask : pair.set_mask),
      .i_clr((sel == gpdpc_pkg::UPD_DIR) ? pair.set_mask : pair.clr_mask),
      .i_valid(gpdpc_pkg::PIN_MASK),
      .i_clr_wins(mu_clr_wins),
      .o_next(mu_next)
   );

   // next state of all four words
   always_comb begin
      next_st = st;
      next_pen_raw = mu_next;
      if (do_apply) begin
         case (sel)
            // R03 R04 direction update
            // R06 pull untouched
            gpdpc_pkg::UPD_DIR: next_st.dir_out = mu_next;
            // R07 R08 level update
            gpdpc_pkg::UPD_LVL: next_st.level = mu_next;
            // R11 R13 R14 pull enable, crystal pins kept
            gpdpc_pkg::UPD_PEN: next_st.pull_en = (next_pen_raw & ~i_xtal_pin) | (st.pull_en & i_xtal_pin);
            // R15 R16 polarity update
            default: next_st.pull_up = mu_next;
         endcase
      end
   end

   // R20 single-cycle apply
   // R02 R12 R15 reset defaults
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st.dir_out <= gpdpc_pkg::RST_DIR_OUT;
         st.level <= gpdpc_pkg::RST_LEVEL;
         st.pull_en <= gpdpc_pkg::RST_PULL_EN;
         st.pull_up <= gpdpc_pkg::RST_PULL_UP;
      end else begin
         st <= next_st;
      end
   end

   // two-flop synchronisers for pin levels and ownership
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         pin_meta <= '0;
         pin_sync <= '0;
         own_meta <= '0;
         own_sync <= '0;
      end else begin
         pin_meta <= i_pin_in;
         pin_sync <= pin_meta;
         own_meta <= i_periph_own;
         own_sync <= own_meta;
      end
   end

   // pin drivers; owned pins released to the peripheral
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pin_oe <= '0;
         o_pin_out <= '0;
         o_pull_en <= gpdpc_pkg::RST_PULL_EN;
         o_pull_up <= gpdpc_pkg::RST_PULL_UP;
      end else begin
         // R01 R05 R09 R10 held while owned or input
         o_pin_oe <= st.dir_out & ~own_sync & gpdpc_pkg::PIN_MASK;
         o_pin_out <= st.level & st.dir_out & ~own_sync & gpdpc_pkg::PIN_MASK;
         o_pull_en <= st.pull_en;
         o_pull_up <= st.pull_up;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         case (i_addr)
            gpdpc_pkg::ADDR_RD_DIR: o_rdata <= st.dir_out;
            gpdpc_pkg::ADDR_RD_LVL: o_rdata <= st.level;
            gpdpc_pkg::ADDR_RD_PEN: o_rdata <= st.pull_en;
            // R18 polarity readback
            gpdpc_pkg::ADDR_RD_POL: o_rdata <= st.pull_up;
            // R19 pin levels
            gpdpc_pkg::ADDR_RD_PINS: o_rdata <= pin_sync & gpdpc_pkg::PIN_MASK;
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end
endmodule

// *** pkg/gpdpc_pkg.sv ***
// Overview of operation
// R01 - eighteen two-way pins at mask bits 0-15, 17, 18; other bits ignored
// R02 - after reset every two-way pin is an input
// R03 - input mask makes inputs, output mask makes outputs, others keep direction
// R04 - bit set in both direction masks makes the pin an input
// R05 - direction stored while a peripheral owns the pin, applied on release
// R06 - direction updates never touch pull enables
// R07 - on mask drives high, off mask drives low, others keep level
// R08 - bit set in both level masks gives low
// R09 - level stored for input pins, driven once pin becomes output
// R10 - level stays pending while peripheral owns pin, applied on release
// R11 - pull enable on/off masks act regardless of direction
// R12 - pull resistors of all pins enabled after reset
// R13 - bit set in both pull enable masks disables the pull
// R14 - pull enables apply even when owned, except the crystal pins
// R15 - up/down masks pick pull polarity; reset pull-down on pins 3,7,8,12,13,14
// R16 - bit set in both polarity masks selects pull-up
// R17 - software should set polarity before enabling the pull
// R18 - polarity read back: 1 pull-up, 0 pull-down, enabled or not
// R19 - level read returns every pin level; unused bits read zero
// R20 - each mask pair applies in one cycle; reset restores defaults
package gpdpc_pkg;
   localparam int unsigned MASK_W = 32;
   localparam logic [31:0] PIN_MASK = 32'h0006ffff;
   localparam logic [31:0] RST_DIR_OUT = 32'h00000000;
   localparam logic [31:0] RST_LEVEL = 32'h00000000;
   localparam logic [31:0] RST_PULL_EN = 32'h0006ffff;
   // pull-down on pins 3, 7, 8, 12, 13 and 14, pull-up on the other real pins
   localparam logic [31:0] RST_PULL_UP = 32'h00068e77;
   // word offsets of the command/readback port
   localparam logic [3:0] ADDR_DIR_IN = 4'h0;
   localparam logic [3:0] ADDR_DIR_OUT = 4'h1;
   localparam logic [3:0] ADDR_LVL_ON = 4'h2;
   localparam logic [3:0] ADDR_LVL_OFF = 4'h3;
   localparam logic [3:0] ADDR_PEN_ON = 4'h4;
   localparam logic [3:0] ADDR_PEN_OFF = 4'h5;
   localparam logic [3:0] ADDR_POL_UP = 4'h6;
   localparam logic [3:0] ADDR_POL_DOWN = 4'h7;
   localparam logic [3:0] ADDR_APPLY = 4'h8;
   localparam logic [3:0] ADDR_RD_DIR = 4'h9;
   localparam logic [3:0] ADDR_RD_LVL = 4'ha;
   localparam logic [3:0] ADDR_RD_PEN = 4'hb;
   localparam logic [3:0] ADDR_RD_POL = 4'hc;
   localparam logic [3:0] ADDR_RD_PINS = 4'hd;
   localparam logic [1:0] UPD_DIR = 2'h0;
   localparam logic [1:0] UPD_LVL = 2'h1;
   localparam logic [1:0] UPD_PEN = 2'h2;
   localparam logic [1:0] UPD_POL = 2'h3;
   typedef struct packed {
      logic [31:0] set_mask;
      logic [31:0] clr_mask;
   } gpdpc_pair_t;
   typedef struct packed {
      logic [31:0] dir_out;
      logic [31:0] level;
      logic [31:0] pull_en;
      logic [31:0] pull_up;
   } gpdpc_state_t;
endpackage

// *** verilog/gpdpc_mask_update.sv ***
`timescale 1ns/100ps
// one set/clear mask pair applied to a held word; clr_wins picks the tie
module gpdpc_mask_update #(
   parameter int unsigned WIDTH = 32
) (
   input wire logic [WIDTH-1:0] i_cur,
   input wire logic [WIDTH-1:0] i_set,
   input wire logic [WIDTH-1:0] i_clr,
   input wire logic [WIDTH-1:0] i_valid,
   input wire logic i_clr_wins,
   output logic [WIDTH-1:0] o_next
);
   logic [WIDTH-1:0] set_eff;
   logic [WIDTH-1:0] clr_eff;
   // both-set resolution, masked to real pins
   always_comb begin
      if (i_clr_wins) begin
         set_eff = i_set & ~i_clr & i_valid;
         clr_eff = i_clr & i_valid;
      end else begin
         set_eff = i_set & i_valid;
         clr_eff = i_clr & ~i_set & i_valid;
      end
      o_next = (i_cur | set_eff) & ~clr_eff;
   end
endmodule

// *** testbench/gpdpc_props.sv ***
`timescale 1ns/100ps
// port checks for the pin port
module gpdpc_props (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [31:0] i_xtal_pin,
   input wire logic [31:0] o_pin_out,
   input wire logic [31:0] o_pin_oe,
   input wire logic [31:0] o_pull_en,
   input wire logic [31:0] o_pull_up
);
   localparam logic [31:0] PM = gpdpc_pkg::PIN_MASK;
   // apply strobe
   wire logic ap = i_wr && i_addr == gpdpc_pkg::ADDR_APPLY;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   AST_RST: assert property ($fell(i_rst) |-> o_pin_oe == 0 && o_pull_en == PM && o_pull_up == gpdpc_pkg::RST_PULL_UP)
      else $error("reset state wrong");
   AST_UNUSED: assert property (((o_pin_oe | o_pin_out | o_pull_en) & ~PM) == 0)
      else $error("unused pin bit active");
   AST_NODRIVE: assert property ((o_pin_out & ~o_pin_oe) == 0)
      else $error("input pin driven");
   AST_PEN_SRC: assert property (!$stable(o_pull_en) |-> $past(ap && i_wdata[1:0] == 2'h2, 2))
      else $error("pull enable moved without its update");
   AST_POL_SRC: assert property (!$stable(o_pull_up) |-> $past(ap && i_wdata[1:0] == 2'h3, 2))
      else $error("polarity moved without its update");
   AST_XTAL: assert property (((o_pull_en ^ $past(o_pull_en)) & $past(i_xtal_pin, 2)) == 0)
      else $error("crystal pin pull changed");
   AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 0)
      else $error("read data outside read slot");
   AST_RD_PINS: assert property ($past(i_rd && i_addr == 4'hd) |-> (o_rdata & ~PM) == 0)
      else $error("unused pin level bit set");
   // main scenarios
   cover property (ap && i_wdata[1:0] == 2'h0);
   cover property (!$stable(o_pull_en));
   cover property ($rose(o_pin_oe[0]));
endmodule

// *** testbench/gpdpc_pins_model.sv ***
`timescale 1ns/100ps
// outside circuitry on the two-way pins
module gpdpc_pins_model (
   input wire logic i_sys_clk,
   input wire logic [31:0] i_oe,
   input wire logic [31:0] i_out,
   input wire logic [31:0] i_pen,
   input wire logic [31:0] i_pup,
   output logic [31:0] o_pin
);
   logic [31:0] flt = 32'h0;
   // floating lines wander every cycle
   always @(posedge i_sys_clk) flt <= ~flt;
   // driven pins follow the port, pulled pins sit at the pull level
   assign o_pin = (i_oe & i_out) | (~i_oe & i_pen & i_pup) | (~i_oe & ~i_pen & flt);
endmodule

// *** testbench/gpdpc_top_bench.sv ***
`timescale 1ns/100ps
// self-checking bench for the pin port
module gpdpc_top_bench;
   localparam logic [31:0] P = gpdpc_pkg::PIN_MASK;
   logic i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, rd_q = 0;
   logic [3:0] i_addr = 0;
   logic [31:0] i_wdata = 0, own = 0, xt = 0, o_rdata, oe, out, pen, pup, pin, a, b, m, me, mm;
   logic [31:0] dir = 0, lvl = 0, pe = gpdpc_pkg::RST_PULL_EN, pol = gpdpc_pkg::RST_PULL_UP;
   logic [63:0] q[$];
   int err_total = 0, check_count = 0, seed = 99225, cyc = 0;
   always #2.5 i_sys_clk = ~i_sys_clk;
   gpdpc_top dut_u (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_periph_own(own),
      .i_xtal_pin(xt), .i_pin_in(pin), .o_pin_out(out), .o_pin_oe(oe), .o_pull_en(pen), .o_pull_up(pup));
   gpdpc_pins_model ext_u (.i_sys_clk, .i_oe(oe), .i_out(out), .i_pen(pen), .i_pup(pup), .o_pin(pin));
   task automatic chk(input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one bus cycle, write or read
   task automatic acc(input logic [3:0] ad, input logic [31:0] d, input logic r);
      @(posedge i_sys_clk);
      i_addr <= ad;
      i_wdata <= d;
      i_wr <= !r;
      i_rd <= r;
      @(posedge i_sys_clk);
      i_wr <= 0;
      i_rd <= 0;
   endtask
   task automatic rd(input logic [3:0] ad, input logic [31:0] e, mk);
      q.push_back({mk, e & mk});
      acc(ad, 32'h0, 1);
   endtask
   task automatic upd(input int k, input logic [31:0] s, c);
      acc(4'(2 * k), s, 0);
      acc(4'(2 * k + 1), c, 0);
      acc(4'h8, 32'(k), 0);
      case (k)
         0: dir = (dir | c) & ~s;
         1: lvl = (lvl | s) & ~c;
         2: pe = (pe & xt) | ((pe | s) & ~c & ~xt);
         default: pol = (pol & ~c) | s;
      endcase
   endtask
   task automatic check_all();
      repeat (4) @(posedge i_sys_clk);
      rd(4'h9, dir, P);
      rd(4'ha, lvl, P);
      rd(4'hb, pe, P);
      rd(4'hc, pol, P);
      rd(4'he, 32'h0, '1);
      m = dir & ~own & P;
      rd(4'hd, (m & lvl) | (~m & pe & pol & P), m | pe | ~P);
      #1;
      chk(oe, m);
      chk(out, m & lvl);
      chk(pen, pe & P);
      chk(pup & P, pol & P);
   endtask
   // read monitor pairs each answer with the oldest note
   always @(posedge i_sys_clk) rd_q <= i_rd;
   always @(negedge i_sys_clk) begin
      if (rd_q) begin
         {mm, me} = q.pop_front();
         chk(o_rdata & mm, me);
      end
   end
   // hang guard
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      xt = $random(seed) & P;
      repeat (10) @(posedge i_sys_clk);
      i_rst <= 0;
      check_all();
      $display("test reset done");
      acc(4'hf, '1, 0);
      // polarity programmed before the pull is enabled
      upd(3, gpdpc_pkg::RST_PULL_UP, ~gpdpc_pkg::RST_PULL_UP);
      upd(2, P, 32'h0);
      check_all();
      for (int i = 0; i < 200; i++) begin
         a = $random(seed);
         b = (i % 3 == 0) ? a : $random(seed);
         upd(i % 4, a, b);
         if (i % 16 == 0) own <= $random(seed);
         check_all();
      end
      $display("test updates done");
      // let the last read answer be checked before reset clears it
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1;
      repeat (3) @(posedge i_sys_clk);
      i_rst <= 0;
      {dir, lvl, pe, pol} = {64'h0, gpdpc_pkg::RST_PULL_EN, gpdpc_pkg::RST_PULL_UP};
      check_all();
      $display("test rereset done");
      finish_test();
   end
endmodule
bind gpdpc_top gpdpc_props chk_u (.*);
